// ---- pkg/mmu_hist_pkg.sv ----
// Constants, types and register map of the translation and history block.
// Assumes a 32-bit Wishbone bus and a real-mode data cache port.
package mmu_hist_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_PT_BASE = 8'h08;
	localparam logic [7:0] REG_TLB_INV = 8'h0C;
	localparam logic [7:0] REG_BAT     = 8'h10;
	localparam logic [7:0] REG_SEG     = 8'h40;
	localparam int NUM_BAT = 4;
	localparam int NUM_SEG = 16;
	localparam int NUM_TLB = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int CTRL_ITE = 0;
	localparam int CTRL_DTE = 1;
	localparam int CTRL_ICE = 2;
	localparam int CTRL_DCE = 3;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_MULTI = 1;
	// ****************************************
	// Memory attribute bits: W I M G
	// ****************************************
	localparam logic [3:0] ATTR_REAL   = 4'h3;
	localparam logic [3:0] ATTR_UPDATE = 4'h2;
	localparam int ATTR_I = 2;
	// ****************************************
	// Block entry, segment and page table entry layouts
	// ****************************************
	localparam int BAT_EA_LO = 20;
	localparam int BAT_PA_LO = 8;
	localparam int BAT_AT_LO = 4;
	localparam int BAT_IV = 1;
	localparam int BAT_DV = 0;
	localparam int SEG_T = 31;
	localparam int PTE_V = 0;
	localparam int PTE_AT_LO = 3;
	localparam int PPN_LO = 12;
	localparam logic [31:0] PTE_R_MASK = 32'h0000_0002;
	localparam logic [31:0] PTE_C_MASK = 32'h0000_0004;
	localparam int PTE_C = 2;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_PTE_RD = 2'b01,
		ST_PTE_WR = 2'b10
	} state_t;

	typedef struct packed {
		logic [31:0] ea;
		logic        is_instr;
		logic        is_write;
		logic        is_touch;
	} access_req_t;

	typedef struct packed {
		logic [31:0] pa;
		logic [3:0]  attr;
		logic        cacheable;
		logic        fault;
		logic        noop;
		logic        direct;
	} access_resp_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        we;
		logic [3:0]  attr;
		logic        real_mode;
	} mem_req_t;

	typedef struct packed {
		logic        valid;
		logic [39:0] vpn;
		logic [19:0] ppn;
		logic [3:0]  attr;
		logic        chg;
	} tlb_entry_t;
endpackage : mmu_hist_pkg

// ---- verilog/mmu_translation_history.sv ----
// Address translation with block entries, a small TLB and history recording.
// Assumes the pipeline takes each one-cycle answer and the cache port acks.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - translation off passes address through unchanged, except that a multiple block hit faults
// - real data accesses use attributes 0011
// - real fetches use 0011, cacheable and guarded
// - instruction cacheability ignores write-through, coherence
// - block entries are not cleared by reset
// - multiple block hits flagged as error
// - hard reset leaves blocks undefined, soft reset keeps
// - block hit beats segment/page translation
// - 256-Mbyte segments, 4-Kbyte pages, 52-bit virtual
// - history only for paged, translated, non-direct accesses
// - hit write with state 10 searches table
// - TLB hit implies referenced flag set
// - miss search sets referenced flag, and changed flag on non-touch writes
// - touch hints are no-ops on a miss
// - history updates go out as real accesses
// - referenced flag set on every paged access that is not a touch miss or a fault
// - hardware never clears a referenced flag
// - updates are cacheable, unguarded, coherence required
module mmu_translation_history (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      soft_reset_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [7:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic                      req_valid_i,
	input  wire mmu_hist_pkg::access_req_t req_i,
	output logic                           req_ready_o,
	output logic                           resp_valid_o,
	output mmu_hist_pkg::access_resp_t     resp_o,
	output logic                           mem_valid_o,
	output mmu_hist_pkg::mem_req_t         mem_o,
	input  wire logic                      mem_ack_i,
	input  wire logic [31:0]               mem_rdata_i,
	output logic                           icache_enable_o,
	output logic                           dcache_enable_o
);
	import mmu_hist_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic multi(input logic [NUM_BAT-1:0] v);
		return (v & (v - 1'b1)) != '0;
	endfunction : multi

	// ****************************************
	// Storage
	// ****************************************
	logic [31:0]  ctrl_reg;
	logic [31:0]  pt_base_reg;
	logic         multi_err_reg;
	logic [31:0]  bat_reg [NUM_BAT];
	logic [31:0]  seg_reg [NUM_SEG];
	tlb_entry_t   tlb_reg [NUM_TLB];
	logic [1:0]   rr_reg;
	logic [1:0]   hit_idx_reg;
	logic         was_hit_reg;
	access_req_t  cur_reg;
	logic [39:0]  vpn_reg;
	state_t       state_reg;
	state_t       state_next;
	logic         ready_reg;
	logic         resp_valid_reg;
	access_resp_t resp_reg;
	logic         mem_valid_reg;
	mem_req_t     mem_reg;
	logic [31:0]  wb_dat_reg;
	logic         wb_ack_reg;

	// ****************************************
	// Lookup of the incoming access
	// ****************************************
	logic               accept;
	logic               xlate;
	logic [NUM_BAT-1:0] bat_vec;
	logic [NUM_TLB-1:0] tlb_vec;
	logic [31:0]        bat_sel;
	logic [1:0]         tlb_idx;
	logic [31:0]        seg;
	logic [39:0]        vpn;
	logic               wr_eff;
	logic [31:0]        pte_new;
	logic [31:0]        fill_pte;
	logic               fill_now;
	logic               resp_fire;
	access_resp_t       resp_next;
	logic               wb_req;
	logic               wb_wr;

	assign accept = req_valid_i && ready_reg;
	assign xlate  = req_i.is_instr ? ctrl_reg[CTRL_ITE] : ctrl_reg[CTRL_DTE];
	assign seg    = seg_reg[req_i.ea[31:28]];
	// Segment number picks the VSID; 24 + 16 page bits + 12 offset = 52
	assign vpn    = {seg[23:0], req_i.ea[27:12]};
	// Touch hints never set the changed flag, so they count as reads
	assign wr_eff = cur_reg.is_write && !cur_reg.is_touch;
	assign pte_new = mem_rdata_i | PTE_R_MASK | (wr_eff ? PTE_C_MASK : '0);
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;
	assign wb_wr  = wb_req && wb_we_i;

	for (genvar g = 0; g < NUM_BAT; g++) begin : g_bat
		assign bat_vec[g] = (req_i.is_instr ? bat_reg[g][BAT_IV] : bat_reg[g][BAT_DV]) &&
		                    bat_reg[g][31:BAT_EA_LO] == req_i.ea[31:BAT_EA_LO];
	end
	for (genvar g = 0; g < NUM_TLB; g++) begin : g_tlb
		assign tlb_vec[g] = tlb_reg[g].valid && tlb_reg[g].vpn == vpn;
	end

	always_comb begin
		bat_sel = '0;
		tlb_idx = '0;
		for (int i = 0; i < NUM_BAT; i++) begin
			if (bat_vec[i]) begin
				bat_sel = bat_reg[i];
			end
		end
		for (int i = 0; i < NUM_TLB; i++) begin
			if (tlb_vec[i]) begin
				tlb_idx = i[1:0];
			end
		end
	end

	// ****************************************
	// Sequencing
	// ****************************************
	always_comb begin
		state_next = state_reg;
		resp_fire  = 1'b0;
		resp_next  = '0;
		fill_now   = 1'b0;
		fill_pte   = mem_rdata_i;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					resp_fire = 1'b1;
					if (multi(bat_vec)) begin
						resp_next.fault = 1'b1;
					end else if (!xlate) begin
						resp_next.pa   = req_i.ea;
						resp_next.attr = ATTR_REAL;
					end else if (bat_vec != '0) begin
						// Block path records no history at all
						resp_next.pa = {bat_sel[BAT_EA_LO-1:BAT_PA_LO],
						                req_i.ea[BAT_EA_LO-1:0]};
						resp_next.attr = bat_sel[BAT_PA_LO-1:BAT_AT_LO];
					end else if (seg[SEG_T]) begin
						resp_next.pa     = req_i.ea;
						resp_next.direct = 1'b1;
					end else if (tlb_vec != '0) begin
						// Referenced is implied by the hit; only a clean write searches
						if (req_i.is_write && !req_i.is_touch &&
						    !tlb_reg[tlb_idx].chg) begin
							resp_fire  = 1'b0;
							state_next = ST_PTE_RD;
						end else begin
							resp_next.pa   = {tlb_reg[tlb_idx].ppn, req_i.ea[PPN_LO-1:0]};
							resp_next.attr = tlb_reg[tlb_idx].attr;
						end
					end else if (req_i.is_touch) begin
						resp_next.noop = 1'b1;
					end else begin
						resp_fire  = 1'b0;
						state_next = ST_PTE_RD;
					end
				end
			end
			ST_PTE_RD: begin
				if (mem_ack_i) begin
					if (!mem_rdata_i[PTE_V]) begin
						resp_fire       = 1'b1;
						resp_next.fault = 1'b1;
						state_next      = ST_IDLE;
					end else if (pte_new != mem_rdata_i) begin
						state_next = ST_PTE_WR;
					end else begin
						fill_now   = 1'b1;
						resp_fire  = 1'b1;
						state_next = ST_IDLE;
					end
				end
			end
			ST_PTE_WR: begin
				fill_pte = mem_reg.wdata;
				if (mem_ack_i) begin
					fill_now   = 1'b1;
					resp_fire  = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (state_reg != ST_IDLE) begin
			resp_next.pa   = {fill_pte[31:PPN_LO], cur_reg.ea[PPN_LO-1:0]};
			resp_next.attr = fill_pte[PTE_AT_LO+3:PTE_AT_LO];
			resp_next.fault = !fill_pte[PTE_V];
		end
		// Cacheability comes from I alone: W and M do not steer the icache
		resp_next.cacheable = !resp_next.attr[ATTR_I];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_i) begin
			state_reg <= ST_IDLE;
			ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ready_reg <= state_next == ST_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (accept) begin
			cur_reg     <= req_i;
			vpn_reg     <= vpn;
			hit_idx_reg <= tlb_idx;
			was_hit_reg <= tlb_vec != '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_i) begin
			resp_valid_reg <= 1'b0;
			resp_reg       <= '0;
		end else begin
			resp_valid_reg <= resp_fire;
			resp_reg       <= resp_next;
		end
	end

	// ****************************************
	// Table search port
	// ****************************************
	// Updates behave as real, cacheable, unguarded, coherent accesses;
	// the data cache hides them on a hit and line-fills on a miss
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_i) begin
			mem_valid_reg <= 1'b0;
			mem_reg       <= '0;
		end else if (state_reg == ST_IDLE && state_next == ST_PTE_RD) begin
			mem_valid_reg     <= 1'b1;
			mem_reg.addr      <= {pt_base_reg[31:PPN_LO], vpn[25:16] ^ vpn[9:0], 2'b00};
			mem_reg.we        <= 1'b0;
			mem_reg.wdata     <= '0;
			mem_reg.attr      <= ATTR_UPDATE;
			mem_reg.real_mode <= 1'b1;
		end else if (state_reg == ST_PTE_RD && state_next == ST_PTE_WR) begin
			// Only ever ORs flags in, so referenced is never cleared
			mem_reg.we    <= 1'b1;
			mem_reg.wdata <= pte_new;
		end else if (mem_ack_i) begin
			mem_valid_reg <= 1'b0;
		end
	end

	// ****************************************
	// TLB
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_i) begin
			rr_reg <= '0;
			for (int i = 0; i < NUM_TLB; i++) begin
				tlb_reg[i] <= '0;
			end
		end else if (wb_wr && wb_adr_i == REG_TLB_INV) begin
			for (int i = 0; i < NUM_TLB; i++) begin
				tlb_reg[i].valid <= 1'b0;
			end
		end else if (fill_now) begin
			// Refill the entry that hit so a cleared C does not linger twice
			tlb_reg[was_hit_reg ? hit_idx_reg : rr_reg] <=
				'{1'b1, vpn_reg, fill_pte[31:PPN_LO],
				  fill_pte[PTE_AT_LO+3:PTE_AT_LO], fill_pte[PTE_C]};
			if (!was_hit_reg) begin
				rr_reg <= rr_reg + 2'd1;
			end
		end
	end

	// ****************************************
	// Wishbone registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_i) begin
			ctrl_reg    <= CTRL_RST;
			pt_base_reg <= '0;
		end else if (wb_wr && wb_adr_i == REG_CTRL) begin
			ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
		end else if (wb_wr && wb_adr_i == REG_PT_BASE) begin
			pt_base_reg <= merge(pt_base_reg, wb_dat_i, wb_sel_i);
		end
	end

	// No reset branch: block entries come up as whatever the flops hold
	// and survive a soft reset untouched
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NUM_BAT; i++) begin
			if (wb_wr && wb_adr_i == REG_BAT + 8'(4 * i)) begin
				bat_reg[i] <= merge(bat_reg[i], wb_dat_i, wb_sel_i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NUM_SEG; i++) begin
			if (wb_wr && wb_adr_i == REG_SEG + 8'(4 * i)) begin
				seg_reg[i] <= merge(seg_reg[i], wb_dat_i, wb_sel_i);
			end
		end
	end

	// Sticky error: a new hit beats a write-one clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			multi_err_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && accept && multi(bat_vec)) begin
			multi_err_reg <= 1'b1;
		end else if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[STAT_MULTI]) begin
			multi_err_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= '0;
		end else begin
			wb_ack_reg <= wb_req;
			wb_dat_reg <= '0;
			if (wb_req && !wb_we_i) begin
				if (wb_adr_i == REG_CTRL) begin
					wb_dat_reg <= ctrl_reg;
				end else if (wb_adr_i == REG_STATUS) begin
					wb_dat_reg <= {30'd0, multi_err_reg, state_reg != ST_IDLE};
				end else if (wb_adr_i == REG_PT_BASE) begin
					wb_dat_reg <= pt_base_reg;
				end else if (wb_adr_i >= REG_BAT && wb_adr_i < REG_BAT + 8'(4 * NUM_BAT)) begin
					wb_dat_reg <= bat_reg[wb_adr_i[3:2]];
				end else if (wb_adr_i >= REG_SEG && wb_adr_i < REG_SEG + 8'(4 * NUM_SEG)) begin
					wb_dat_reg <= seg_reg[wb_adr_i[5:2]];
				end
			end
		end
	end

	assign wb_dat_o        = wb_dat_reg;
	assign wb_ack_o        = wb_ack_reg;
	assign req_ready_o     = ready_reg;
	assign resp_valid_o    = resp_valid_reg;
	assign resp_o          = resp_reg;
	assign mem_valid_o     = mem_valid_reg;
	assign mem_o           = mem_reg;
	assign icache_enable_o = ctrl_reg[CTRL_ICE];
	assign dcache_enable_o = ctrl_reg[CTRL_DCE];

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || soft_reset_i);

	sequence s_real_acc;
		accept && !xlate && !multi(bat_vec);
	endsequence
	sequence s_touch_miss;
		accept && xlate && bat_vec == '0 && !seg[SEG_T] && tlb_vec == '0 && req_i.is_touch;
	endsequence

	chk_real_addr: assert property (s_real_acc |=> resp_valid_o && resp_o.pa == $past(req_i.ea))
		else $error("real mode address altered");
	chk_real_data: assert property (s_real_acc ##0 !req_i.is_instr |=> resp_o.attr == 4'h3)
		else $error("real data attribute wrong");
	chk_real_fetch: assert property (s_real_acc ##0 req_i.is_instr |=> resp_o.attr == 4'h3 && resp_o.cacheable)
		else $error("real fetch attribute wrong");
	chk_touch_miss_noop: assert property (s_touch_miss |=> resp_o.noop && !mem_valid_o)
		else $error("touch miss started search");
	chk_bat_no_search: assert property (accept && xlate && bat_vec != '0 |=> !mem_valid_o [*2])
		else $error("block hit touched page table");
	chk_update_attr: assert property (mem_valid_o |-> mem_o.attr == 4'h2 && mem_o.real_mode)
		else $error("update access attributes wrong");
	chk_hit_write_search: assert property (accept && xlate && bat_vec == '0 && !seg[SEG_T] &&
		tlb_vec != '0 && req_i.is_write && !req_i.is_touch && !tlb_reg[tlb_idx].chg
		|=> mem_valid_o && !mem_o.we)
		else $error("clean write hit did not search");
	// Only the first write cycle: the cache may change its read data after the ack
	chk_ref_kept: assert property (mem_valid_o && $rose(mem_o.we) |-> mem_o.wdata[1] &&
		(mem_o.wdata & $past(mem_rdata_i)) == $past(mem_rdata_i))
		else $error("update cleared a history flag");
	chk_multi_sticky: assert property (accept && multi(bat_vec) |=> multi_err_reg && resp_o.fault)
		else $error("multiple block hit not flagged");
endmodule : mmu_translation_history

`default_nettype wire

// ---- dv/pt_memory_model.sv ----
// Behavioural data cache that serves the block's page table search accesses.
// Assumes one request at a time, held on mem_valid_i until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module pt_memory_model (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic [3:0]             lat_i,
	input  wire logic                   mem_valid_i,
	input  wire mmu_hist_pkg::mem_req_t mem_i,
	output logic                        mem_ack_o,
	output logic [31:0]                 mem_rdata_o
);
	import mmu_hist_pkg::*;
	// ****************************************
	// Storage and trace of update writes
	// ****************************************
	logic [31:0] mem [0:1023];
	logic [3:0]  wait_cnt;
	int          n_req;
	int          n_wr;
	logic [31:0] last_addr;
	logic [31:0] last_wdata;
	logic [3:0]  last_attr;
	logic        last_real;
	initial begin
		mem_ack_o = 1'h0;
		mem_rdata_o = 32'h0;
		wait_cnt = 4'h0;
		n_req = 0;
		n_wr = 0;
	end
	// ****************************************
	// Answer after lat_i idle cycles
	// ****************************************
	// Read data toggles outside the ack cycle so a stale sample cannot pass
	always @(posedge clk_i) begin
		if (rst_i || mem_ack_o || !mem_valid_i) begin
			mem_ack_o <= 1'h0;
			wait_cnt <= 4'h0;
			mem_rdata_o <= ~mem_rdata_o;
		end else if (wait_cnt < lat_i) begin
			wait_cnt <= wait_cnt + 4'h1;
			mem_rdata_o <= ~mem_rdata_o;
		end else begin
			mem_ack_o <= 1'h1;
			mem_rdata_o <= mem[mem_i.addr[11:2]];
			n_req <= n_req + 1;
			last_addr <= mem_i.addr;
			if (mem_i.we) begin
				mem[mem_i.addr[11:2]] <= mem_i.wdata;
				n_wr <= n_wr + 1;
				last_wdata <= mem_i.wdata;
				last_attr <= mem_i.attr;
				last_real <= mem_i.real_mode;
			end
		end
	end
endmodule : pt_memory_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the translation and history block.
// Assumes the data cache model above on the search port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mmu_hist_pkg::*;
	typedef struct {
		logic [31:0] ctrl;
		logic [31:0] ea;
		logic        instr;
		logic        touch;
		logic [31:0] pa;
		logic [3:0]  attr;
		logic        noop;
		logic        direct;
	} row_t;
	logic         clk_i, rst_i, soft_reset_i;
	logic         wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]   wb_adr_i;
	logic [3:0]   wb_sel_i, lat;
	logic [31:0]  wb_dat_i, wb_dat_o, mem_rdata_i;
	logic         req_valid_i, req_ready_o, resp_valid_o;
	logic         mem_valid_o, mem_ack_i, icache_enable_o, dcache_enable_o;
	access_req_t  req_i;
	access_resp_t resp_o, s;
	mem_req_t     mem_o;
	int           n_fail, cmp_count, n0;
	row_t rows[8] = '{
		'{32'h0, 32'h1234_5678, 1'h0, 1'h0, 32'h1234_5678, 4'h3, 1'h0, 1'h0},
		'{32'h0, 32'h8765_4320, 1'h1, 1'h0, 32'h8765_4320, 4'h3, 1'h0, 1'h0},
		'{32'hC, 32'h0FED_C000, 1'h0, 1'h0, 32'h0FED_C000, 4'h3, 1'h0, 1'h0},
		'{32'h3, 32'h1001_2345, 1'h0, 1'h0, 32'h2001_2345, 4'hA, 1'h0, 1'h0},
		'{32'h3, 32'h1000_0100, 1'h1, 1'h0, 32'h2000_0100, 4'hA, 1'h0, 1'h0},
		'{32'h3, 32'h1ABC_0010, 1'h0, 1'h0, 32'h1ABC_0010, 4'h0, 1'h0, 1'h1},
		'{32'h3, 32'h3000_0ABC, 1'h0, 1'h0, 32'h4000_0ABC, 4'h5, 1'h0, 1'h0},
		'{32'h3, 32'h2005_0000, 1'h0, 1'h1, 32'h0, 4'h0, 1'h1, 1'h0}
	};

	mmu_translation_history dut (.clk_i(clk_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.resp_valid_o(resp_valid_o), .resp_o(resp_o), .mem_valid_o(mem_valid_o),
		.mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.icache_enable_o(icache_enable_o), .dcache_enable_o(dcache_enable_o));
	pt_memory_model pm (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .mem_valid_i(mem_valid_o),
		.mem_i(mem_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask : chk
	task automatic bound(input int i);
		if (i >= 50) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : bound
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'h1) break;
		end
		bound(i);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, q);
		chk("register read", exp, q);
	endtask : rd
	task automatic xfer(input access_req_t r, output access_resp_t o);
		int i;
		@(posedge clk_i);
		req_valid_i <= 1'h1;
		req_i <= r;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (req_ready_o === 1'h1) break;
		end
		bound(i);
		req_valid_i <= 1'h0;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (resp_valid_o === 1'h1) break;
		end
		bound(i);
		o = resp_o;
	endtask : xfer
	// Page at segment 2, table word index 0x031 under base 0x0010_0000
	task automatic page(input logic we, input logic upd, input logic [31:0] wdata);
		n0 = pm.n_wr;
		xfer('{32'h2003_4567, 1'h0, we, 1'h0}, s);
		chk("page pa", 32'hABCD_E567, s.pa);
		chk("page attr", 32'h2, 32'(s.attr));
		chk("update count", 32'(n0 + int'(upd)), 32'(pm.n_wr));
		if (upd) begin
			chk("update data", wdata, pm.last_wdata);
			chk("update addr", 32'h0010_00C4, pm.last_addr);
			chk("update attr", 32'(ATTR_UPDATE), 32'(pm.last_attr));
			chk("update real", 32'h1, 32'(pm.last_real));
		end
	endtask : page
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		n_fail = 0;
		cmp_count = 0;
		rst_i = 1'h1;
		soft_reset_i = 1'h0;
		{wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i} = 4'h0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		req_i = '0;
		lat = 4'h2;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		rd(REG_CTRL, CTRL_RST);
		chk("cache enables", 32'h0, {30'h0, icache_enable_o, dcache_enable_o});
		rd(8'h80, 32'h0);
		for (int i = 0; i < NUM_BAT; i++) wr(REG_BAT + 8'(4 * i), 32'h0);
		wr(REG_BAT, 32'h1002_00A3);
		wr(REG_BAT + 8'h8, 32'h3004_0051);
		wr(REG_SEG + 8'h4, 32'h8000_0000);
		wr(REG_SEG + 8'h8, 32'h0000_0005);
		wr(REG_PT_BASE, 32'h0010_0000);
		pm.mem[10'h031] = 32'hABCD_E011;
		foreach (rows[k]) begin
			wr(REG_CTRL, rows[k].ctrl);
			n0 = pm.n_req;
			xfer('{rows[k].ea, rows[k].instr, 1'h0, rows[k].touch}, s);
			chk("noop", 32'(rows[k].noop), 32'(s.noop));
			chk("cache enables", 32'(rows[k].ctrl[3:2]), 32'({dcache_enable_o, icache_enable_o}));
			chk("direct", 32'(rows[k].direct), 32'(s.direct));
			chk("searches", 32'(n0), 32'(pm.n_req));
			if (!rows[k].noop) chk("pa", rows[k].pa, s.pa);
			if (!rows[k].noop && !rows[k].direct) begin
				chk("attr", 32'(rows[k].attr), 32'(s.attr));
				chk("cacheable", 32'(!rows[k].attr[ATTR_I]), 32'(s.cacheable));
			end
		end
		// Slow cache first, then prompt, to cover both answer timings
		lat = 4'h3;
		page(1'h0, 1'h1, 32'hABCD_E013);
		page(1'h0, 1'h0, 32'h0);
		lat = 4'h0;
		page(1'h1, 1'h1, 32'hABCD_E017);
		page(1'h1, 1'h0, 32'h0);
		pm.mem[10'h031] = 32'hABCD_E011;
		wr(REG_TLB_INV, 32'h1);
		page(1'h0, 1'h1, 32'hABCD_E013);
		wr(REG_BAT + 8'h4, 32'h1003_0001);
		wr(REG_CTRL, 32'h0);
		xfer('{32'h1001_0000, 1'h0, 1'h0, 1'h0}, s);
		chk("fault", 32'h1, 32'(s.fault));
		rd(REG_STATUS, 32'h2);
		wr(REG_STATUS, 32'h2);
		rd(REG_STATUS, 32'h0);
		wr(REG_BAT + 8'h4, 32'h0);
		@(posedge clk_i);
		soft_reset_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		soft_reset_i <= 1'h0;
		@(posedge clk_i);
		rd(REG_CTRL, 32'h0);
		wr(REG_CTRL, 32'h3);
		xfer('{32'h1001_2345, 1'h0, 1'h0, 1'h0}, s);
		chk("kept block", 32'h2001_2345, s.pa);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
